// ===== wsc_map.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 watchdog and supervisor block.
 Assumes it is included by its bare name wherever a constant is used.
*/
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH

// Register word addresses in memory block zero
`define WSC_ADDR_WD_LO     8'h08
`define WSC_ADDR_WD_HI     8'h09
`define WSC_ADDR_CHG       8'h0a
`define WSC_ADDR_FLAG      8'h0b
`define WSC_ADDR_CTRL      8'h0c

// Flag register bits
`define WSC_FLAG_OSF       7
`define WSC_FLAG_WF        6

// Control register bits
`define WSC_CTRL_OSCILLATOR_DISABLE_ON_BATTERY      7
`define WSC_CTRL_WDE       1
`define WSC_CTRL_WDRST     0

// Charger configuration fields
`define WSC_CHG_KEY_F      7:4
`define WSC_CHG_DIODE_F    3:2
`define WSC_CHG_RES_F      1:0
`define WSC_CHG_KEY        4'ha
`define WSC_DIODE_NONE     2'b01
`define WSC_DIODE_ONE      2'b10
`define WSC_RES_OFF        2'b00

// Reset values
`define WSC_CHG_RESET      8'h00
`define WSC_CTRL_BIT_RESET 1'b0
`define WSC_OSF_RESET      1'b1
`define WSC_WF_RESET       1'b0
`define WSC_WD_RESET       16'h0000

// Watchdog counter
`define WSC_WD_DIGITS      4
`define WSC_BCD_MAX        4'h9
`define WSC_WD_ONE         16'h0001

// Timing, in milliseconds, and the clock rate in kHz
`define WSC_CLK_KHZ        40
`define WSC_T_RST_MS       250
`define WSC_T_DEBOUNCE_MS  250
`define WSC_T_OSC_START_MS 1000

`endif

// ===== wsc_pkg.sv
/*
 Types shared by the watchdog and supervisor block.
 Assumes nothing of its surroundings.
*/
package wsc_pkg;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wsc_req_t;

   typedef struct packed {
      logic       valid;
      logic       ack;
      logic [7:0] data;
   } wsc_rsp_t;

   typedef struct packed {
      logic       on;
      logic       diode;
      logic [1:0] res;
   } wsc_charger_t;

   typedef enum logic [2:0] {
      WSC_IDLE      = 3'b000,
      WSC_PFAIL     = 3'b001,
      WSC_HOLD      = 3'b010,
      WSC_DEBOUNCE  = 3'b011,
      WSC_WAIT_RISE = 3'b100
   } wsc_state_t;

endpackage : wsc_pkg

// ===== wsc_bcd_digit.sv
/*
 One BCD digit of the watchdog down counter, with load and borrow.
 Assumes load and dec are synchronous to clk; load wins over dec.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wsc_map.svh"

module wsc_bcd_digit
   import wsc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       load,
   input  wire logic [3:0] load_val,
   input  wire logic       dec,
   output var  logic [3:0] val,
   output      logic       is_zero
);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         val <= 4'h0;
      end else if (load) begin
         val <= load_val;
      end else if (dec) begin
         val <= is_zero ? `WSC_BCD_MAX : val - 4'h1;
      end
   end

   assign is_zero = (val == 4'h0);

endmodule : wsc_bcd_digit
`default_nettype wire

// ===== wsc_top.sv
/*
 Watchdog, reset supervisor and special-purpose registers.
 Assumes a serial slave front end that presents one-cycle byte requests,
 a 100 Hz tick pulse, and an open-drain reset pin resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wsc_map.svh"

// Operation
// - Watchdog is a four-digit BCD down counter at 08h-09h, 10 ms steps.
// - Writing the watchdog loads counter and seed; reloads use the seed.
// - Reading the watchdog returns a held snapshot; an enabled nonzero count reloads from the seed.
// - With enable clear, counter is still; registers are plain storage.
// - Zero written while enabled keeps the counter stopped, no flag.
// - Enabled nonzero counter drops each tick; at zero stops, sets flag.
// - Expiry with reset-drive set pulses reset low and blocks access.
// - A watchdog write, or a read while enabled, before expiry reloads from the seed.
// - Expiry with reset-drive clear only sets the flag.
// - Supply fault blocks access, holds reset low, then holds on.
// - Oscillator-off-on-battery adds startup time to that hold.
// - Outside a reset cycle a falling reset pin starts debounce.
// - After debounce wait for release, then hold reset low again.
// - Oscillator stop flag sets on run-to-stop; only writing 0 clears.
// - Expiry flag sets at zero, survives the pulse; only 0 clears.
// - Unused flag and control bits read zero and ignore writes.
// - Control bit 7 stops the oscillator only on battery power.
// - Control bit 1 enables watchdog, bit 0 selects reset drive.
// - Charger runs only with the key pattern in bits 7 to 4.
// - Diode code 01 none, 10 one; 00 and 11 disable charging.
// - Resistor code 01, 10, 11 select 250, 2k, 4k; 00 disables.
// - These registers sit at 08h to 0Ch behind the serial port.
module wsc_top
   import wsc_pkg::*;
#(
   parameter int unsigned RST_HOLD_CYC  = `WSC_T_RST_MS * `WSC_CLK_KHZ,
   parameter int unsigned DEBOUNCE_CYC  = `WSC_T_DEBOUNCE_MS * `WSC_CLK_KHZ,
   parameter int unsigned OSC_START_CYC = `WSC_T_OSC_START_MS * `WSC_CLK_KHZ,
   parameter int unsigned WD_DIGITS     = `WSC_WD_DIGITS
)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire wsc_req_t     req,
   output var  wsc_rsp_t     rsp,
   input  wire logic         tick_100hz,
   input  wire logic         supply_ok,
   input  wire logic         on_battery,
   input  wire logic         osc_running,
   input  wire logic         rst_pin_in,
   output var  logic         rst_pin_out,
   output var  logic         rst_pin_oe,
   output var  logic         access_blocked,
   output var  logic         osc_stop_req,
   output var  wsc_charger_t charger
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (WD_DIGITS != 4) begin : g_bad_digits
      $error("wsc_top: watchdog must be four digits");
   end
   if (RST_HOLD_CYC < 8 || DEBOUNCE_CYC < 1 || OSC_START_CYC < 1) begin : g_bad_time
      $error("wsc_top: timing counts too small");
   end
   if (64'(RST_HOLD_CYC) + 64'(OSC_START_CYC) > 64'h7fffffff) begin : g_bad_sum
      $error("wsc_top: timing counts overflow the timer");
   end

   localparam logic [31:0] HOLD_LOAD = 32'(RST_HOLD_CYC);
   localparam logic [31:0] HOLD_OSC  = 32'(RST_HOLD_CYC + OSC_START_CYC);
   localparam logic [31:0] DB_LOAD   = 32'(DEBOUNCE_CYC);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   wsc_state_t  state;
   wsc_state_t  next_state;
   logic [31:0] timer;
   logic [31:0] next_timer;
   logic [15:0] count;
   logic [15:0] seed;
   logic [15:0] next_seed;
   logic [3:0]  dig_zero;
   logic [3:0]  borrow;
   logic        watchdog_enable;
   logic        wdrst;
   logic        oscillator_disable_on_battery;
   logic [7:0]  chg_cfg;
   logic        oscillator_stop_flag;
   logic        wf;
   logic        osc_prev;
   logic        pin_prev;
   logic [7:0]  rdata;
   logic        blocked;
   logic        acc_wr;
   logic        acc_rd;
   logic        hit_lo;
   logic        hit_hi;
   logic        hit_wd;
   logic        hit_chg;
   logic        hit_flag;
   logic        hit_ctrl;
   logic        mapped;
   logic        load_en;
   logic        run;
   logic        expire;
   logic        pin_fall;
   logic        osc_fall;
   logic        flag_clr_wf;
   logic        flag_clr_osf;

   ////////////////////////////////////////////////////////////////////////
   // Access decode

   // While any reset or power-fail cycle runs, requests are dropped whole
   assign blocked  = (state != WSC_IDLE);
   assign acc_wr   = req.wr & ~blocked;
   assign acc_rd   = req.rd & ~req.wr & ~blocked;
   assign hit_lo   = (req.addr == `WSC_ADDR_WD_LO);
   assign hit_hi   = (req.addr == `WSC_ADDR_WD_HI);
   assign hit_wd   = hit_lo | hit_hi;
   assign hit_chg  = (req.addr == `WSC_ADDR_CHG);
   assign hit_flag = (req.addr == `WSC_ADDR_FLAG);
   assign hit_ctrl = (req.addr == `WSC_ADDR_CTRL);
   assign mapped   = hit_wd | hit_chg | hit_flag | hit_ctrl;

   ////////////////////////////////////////////////////////////////////////
   // Watchdog counter and seed

   always_comb begin
      next_seed = seed;
      if (acc_wr & hit_lo) begin
         next_seed[7:0] = req.wdata;
      end
      if (acc_wr & hit_hi) begin
         next_seed[15:8] = req.wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seed <= `WSC_WD_RESET;
      end else begin
         seed <= next_seed;
      end
   end

   // Reads reload only a live count; after expiry the count stays at zero
   assign load_en = (acc_wr & hit_wd)
                  | (acc_rd & hit_wd & watchdog_enable & (count != 16'h0000));
   assign run     = watchdog_enable & (count != 16'h0000) & ~load_en;
   assign borrow[0] = run & tick_100hz;
   assign expire  = borrow[0] & (count == `WSC_WD_ONE);

   for (genvar i = 0; i < WD_DIGITS; i++) begin : g_digit
      if (i < WD_DIGITS - 1) begin : g_borrow
         assign borrow[i+1] = borrow[i] & dig_zero[i];
      end
      wsc_bcd_digit u_digit (
         .clk      (clk),
         .nrst     (nrst),
         .load     (load_en),
         .load_val (next_seed[4*i +: 4]),
         .dec      (borrow[i]),
         .val      (count[4*i +: 4]),
         .is_zero  (dig_zero[i])
      );
   end

   property p_wd_write;
      acc_wr & hit_lo |=> count[7:0] == $past(req.wdata) && seed[7:0] == $past(req.wdata);
   endproperty
   a_wd_write: assert property (p_wd_write)
      else $error("watchdog write did not load counter and seed");
   property p_wd_reload;
      acc_rd & hit_wd & watchdog_enable & (count > `WSC_WD_ONE) |=> count == $past(seed);
   endproperty
   a_wd_reload: assert property (p_wd_reload)
      else $error("watchdog read did not reload from seed");
   property p_wd_still;
      !watchdog_enable & !load_en |=> $stable(count);
   endproperty
   a_wd_still: assert property (p_wd_still)
      else $error("disabled watchdog changed");
   property p_wd_zero;
      watchdog_enable & (count == 16'h0000) & !load_en |=> count == 16'h0000 && !$rose(wf);
   endproperty
   a_wd_zero: assert property (p_wd_zero)
      else $error("zero watchdog moved or raised the flag");
   property p_wd_expire;
      expire |=> count == 16'h0000 && wf;
   endproperty
   a_wd_expire: assert property (p_wd_expire)
      else $error("expiry did not stop at zero with flag");
   c_expire: cover property (expire ##1 rst_pin_oe);

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer

   assign pin_fall = pin_prev & ~rst_pin_in;

   always_comb begin
      next_state = state;
      next_timer = (timer != 32'h0) ? timer - 32'h1 : timer;
      unique case (state)
         WSC_IDLE: begin
            if (pin_fall) begin
               next_state = WSC_DEBOUNCE;
               next_timer = DB_LOAD;
            end else if (expire & wdrst) begin
               next_state = WSC_HOLD;
               next_timer = HOLD_LOAD;
            end
         end
         WSC_PFAIL: begin
            if (supply_ok) begin
               next_state = WSC_HOLD;
               next_timer = oscillator_disable_on_battery ? HOLD_OSC : HOLD_LOAD;
            end
         end
         WSC_HOLD: begin
            if (timer == 32'h1) begin
               next_state = WSC_IDLE;
            end
         end
         WSC_DEBOUNCE: begin
            if (timer == 32'h1) begin
               next_state = WSC_WAIT_RISE;
            end
         end
         WSC_WAIT_RISE: begin
            if (rst_pin_in) begin
               next_state = WSC_HOLD;
               next_timer = HOLD_LOAD;
            end
         end
         default: begin
            next_state = WSC_IDLE;
         end
      endcase
      // A supply fault overrides every other cycle
      if (!supply_ok) begin
         next_state = WSC_PFAIL;
         next_timer = 32'h0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= WSC_IDLE;
         timer <= 32'h0;
      end else begin
         state <= next_state;
         timer <= next_timer;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_prev       <= 1'b1;
         rst_pin_out    <= 1'b0;
         rst_pin_oe     <= 1'b0;
         access_blocked <= 1'b0;
      end else begin
         pin_prev       <= rst_pin_in;
         rst_pin_out    <= 1'b0;
         // Pin released while waiting for the button, so release is seen
         rst_pin_oe     <= (next_state == WSC_PFAIL) | (next_state == WSC_HOLD)
                         | (next_state == WSC_DEBOUNCE);
         access_blocked <= (next_state != WSC_IDLE);
      end
   end

   property p_pulse;
      (state == WSC_IDLE) & expire & wdrst & supply_ok & !pin_fall
         |=> (rst_pin_oe && access_blocked)[*8];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("watchdog pulse missing");
   property p_no_pulse;
      (state == WSC_IDLE) & expire & !wdrst & supply_ok & !pin_fall |=> !rst_pin_oe;
   endproperty
   a_no_pulse: assert property (p_no_pulse)
      else $error("reset driven with reset-drive clear");
   property p_pfail;
      !supply_ok |=> rst_pin_oe && access_blocked && state == WSC_PFAIL;
   endproperty
   a_pfail: assert property (p_pfail)
      else $error("supply fault did not hold reset");
   property p_pf_hold;
      (state == WSC_PFAIL) & supply_ok & oscillator_disable_on_battery |=> timer == HOLD_OSC;
   endproperty
   a_pf_hold: assert property (p_pf_hold)
      else $error("startup time not added to hold");
   property p_button;
      (state == WSC_IDLE) & pin_fall & supply_ok |=> state == WSC_DEBOUNCE && rst_pin_oe;
   endproperty
   a_button: assert property (p_button)
      else $error("falling pin did not start debounce");
   property p_release;
      (state == WSC_WAIT_RISE) & rst_pin_in & supply_ok
         |=> state == WSC_HOLD && rst_pin_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("release did not start hold");
   c_button: cover property ((state == WSC_DEBOUNCE) ##1 (state == WSC_WAIT_RISE));
   c_pfail: cover property ((state == WSC_PFAIL) ##1 (state == WSC_HOLD));

   ////////////////////////////////////////////////////////////////////////
   // Control and charger registers

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         oscillator_disable_on_battery  <= `WSC_CTRL_BIT_RESET;
         watchdog_enable   <= `WSC_CTRL_BIT_RESET;
         wdrst <= `WSC_CTRL_BIT_RESET;
      end else if (acc_wr & hit_ctrl) begin
         oscillator_disable_on_battery  <= req.wdata[`WSC_CTRL_OSCILLATOR_DISABLE_ON_BATTERY];
         watchdog_enable   <= req.wdata[`WSC_CTRL_WDE];
         wdrst <= req.wdata[`WSC_CTRL_WDRST];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chg_cfg <= `WSC_CHG_RESET;
      end else if (acc_wr & hit_chg) begin
         chg_cfg <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charger      <= '0;
         osc_stop_req <= 1'b0;
      end else begin
         charger.on    <= (chg_cfg[`WSC_CHG_KEY_F] == `WSC_CHG_KEY)
                        & ((chg_cfg[`WSC_CHG_DIODE_F] == `WSC_DIODE_NONE)
                        | (chg_cfg[`WSC_CHG_DIODE_F] == `WSC_DIODE_ONE))
                        & (chg_cfg[`WSC_CHG_RES_F] != `WSC_RES_OFF);
         charger.diode <= (chg_cfg[`WSC_CHG_DIODE_F] == `WSC_DIODE_ONE);
         charger.res   <= chg_cfg[`WSC_CHG_RES_F];
         osc_stop_req  <= oscillator_disable_on_battery & on_battery;
      end
   end

   property p_charger;
      charger.on |-> $past(chg_cfg[`WSC_CHG_KEY_F]) == `WSC_CHG_KEY
         && $past(chg_cfg[`WSC_CHG_RES_F]) != `WSC_RES_OFF;
   endproperty
   a_charger: assert property (p_charger)
      else $error("charger on without key");
   property p_blocked;
      blocked & req.wr |=> $stable({oscillator_disable_on_battery, watchdog_enable, wdrst, chg_cfg, seed});
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("blocked write changed a register");

   ////////////////////////////////////////////////////////////////////////
   // Event flags

   assign osc_fall     = osc_prev & ~osc_running;
   assign flag_clr_wf  = acc_wr & hit_flag & ~req.wdata[`WSC_FLAG_WF];
   assign flag_clr_osf = acc_wr & hit_flag & ~req.wdata[`WSC_FLAG_OSF];

   // A set in the clearing cycle wins so no event is lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_prev <= 1'b0;
         oscillator_stop_flag      <= `WSC_OSF_RESET;
         wf       <= `WSC_WF_RESET;
      end else begin
         osc_prev <= osc_running;
         oscillator_stop_flag      <= osc_fall | (oscillator_stop_flag & ~flag_clr_osf);
         wf       <= expire | (wf & ~flag_clr_wf);
      end
   end

   property p_osf_set;
      osc_fall |=> oscillator_stop_flag;
   endproperty
   a_osf_set: assert property (p_osf_set)
      else $error("oscillator stop not flagged");
   property p_wf_keep;
      wf & !flag_clr_wf |=> wf;
   endproperty
   a_wf_keep: assert property (p_wf_keep)
      else $error("expiry flag lost without a clear");
   property p_osf_keep;
      oscillator_stop_flag & !flag_clr_osf |=> oscillator_stop_flag;
   endproperty
   a_osf_keep: assert property (p_osf_keep)
      else $error("oscillator stop flag lost without a clear");

   ////////////////////////////////////////////////////////////////////////
   // Read data and response

   always_comb begin
      rdata = 8'h00;
      if (hit_lo) begin
         rdata = count[7:0];
      end else if (hit_hi) begin
         rdata = count[15:8];
      end else if (hit_chg) begin
         rdata = chg_cfg;
      end else if (hit_flag) begin
         rdata[`WSC_FLAG_OSF] = oscillator_stop_flag;
         rdata[`WSC_FLAG_WF]  = wf;
      end else if (hit_ctrl) begin
         rdata[`WSC_CTRL_OSCILLATOR_DISABLE_ON_BATTERY]  = oscillator_disable_on_battery;
         rdata[`WSC_CTRL_WDE]   = watchdog_enable;
         rdata[`WSC_CTRL_WDRST] = wdrst;
      end
   end

   // The response data flop is the holding register for watchdog reads
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rsp <= '0;
      end else begin
         rsp.valid <= req.rd | req.wr;
         rsp.ack   <= (req.rd | req.wr) & ~blocked & mapped;
         rsp.data  <= (acc_rd & mapped) ? rdata : 8'h00;
      end
   end

   property p_flag_read;
      acc_rd & hit_flag |=> rsp.valid && rsp.data[5:0] == 6'h00;
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag reserved bits not zero");
   c_flag_clear: cover property (wf ##1 flag_clr_wf ##1 !wf);

endmodule : wsc_top
`default_nettype wire

// ===== wsc_reset_line.sv
/*
 Far-side model of the open-drain reset line: pull-up plus a pushbutton.
 Assumes the block's pin output and enable are fed in, and the level goes back.
*/
`timescale 1ns/1ps
`default_nettype none

module wsc_reset_line (
   input  wire logic oe,
   input  wire logic drive_val,
   input  wire logic pressed,
   output var  logic pin
);
   // Pull-up: a released line reads high, never the last driven value
   always_comb pin = !(pressed || (oe && !drive_val));
endmodule : wsc_reset_line

`default_nettype wire

// ===== testbench.sv
/*
 Self-checking bench of the watchdog and supervisor block.
 Assumes wsc_pkg, wsc_top and wsc_reset_line are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end

module testbench
   import wsc_pkg::*;
;
   localparam int HOLD = 20;
   localparam int DEB  = 10;
   localparam int OSC  = 15;
   logic         clk   = 1'b0;
   logic         nrst  = 1'b0;
   logic         tick  = 1'b0;
   logic         sup   = 1'b1;
   logic         batt  = 1'b0;
   logic         osc   = 1'b1;
   logic         btn   = 1'b0;
   logic         pin, oe, pout, blk, osr;
   wsc_req_t     req   = '0;
   wsc_rsp_t     rsp;
   wsc_charger_t chg;
   int           n_errors = 0, check_count = 0, cyc = 0, n;
   logic [7:0]   mdl [8:12];
   logic [7:0]   d;

   always #12.5 clk = ~clk;

   wsc_top #(.RST_HOLD_CYC(HOLD), .DEBOUNCE_CYC(DEB), .OSC_START_CYC(OSC)) wsc_top_i (
      .clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .tick_100hz(tick),
      .supply_ok(sup), .on_battery(batt), .osc_running(osc), .rst_pin_in(pin),
      .rst_pin_out(pout), .rst_pin_oe(oe), .access_blocked(blk),
      .osc_stop_req(osr), .charger(chg));

   wsc_reset_line wsc_reset_line_i (.oe(oe), .drive_val(pout), .pressed(btn), .pin(pin));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   // Request held from one falling edge to the next, so exactly one rising edge takes it
   task automatic acc(input logic w, input logic [7:0] a, dat, input logic k,
                      output logic [7:0] q);
      @(negedge clk);
      req = '{rd: !w, wr: w, addr: a, wdata: dat};
      @(negedge clk);
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.ack, k)
      q = rsp.data;
      req = '0;
   endtask : acc

   task automatic wr(input logic [7:0] a, dat);
      logic [7:0] q;
      acc(1'b1, a, dat, 1'b1, q);
      if (a == 8'h0b)
         mdl[a] = mdl[a] & dat & 8'hc0;
      else if (a == 8'h0c)
         mdl[a] = dat & 8'h83;
      else
         mdl[a] = dat;
   endtask : wr

   task automatic rd(input logic [7:0] a, exp);
      logic [7:0] q;
      acc(1'b0, a, 8'h00, 1'b1, q);
      `CHK(q, exp)
   endtask : rd

   task automatic tk(input int k);
      repeat (k) begin
         @(negedge clk);
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
      end
   endtask : tk

   // Host keeps enable clear while loading the count, then sets control
   task automatic load(input logic [15:0] v, input logic [7:0] c);
      wr(8'h0c, 8'h00);
      wr(8'h08, v[7:0]);
      wr(8'h09, v[15:8]);
      wr(8'h0c, c);
   endtask : load

   task automatic wait_oe;
      for (int i = 0; i < 60 && oe !== 1'b1; i++)
         @(negedge clk);
   endtask : wait_oe

   task automatic hi_cycles(output int c);
      c = 0;
      while (oe === 1'b1 && c < 500) begin
         @(negedge clk);
         c++;
      end
   endtask : hi_cycles

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end

   initial begin
      void'($urandom(32'h23da));
      mdl = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      for (int a = 8; a <= 12; a++) rd(a[7:0], mdl[a]);
      acc(1'b0, 8'h0d, 8'h00, 1'b0, d);
      `CHK(d, 8'h00)
      wr(8'h0c, 8'hff);
      rd(8'h0c, mdl[12]);
      batt = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(osr, 1'b1)
      batt = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(osr, 1'b0)
      // Half the draws carry the key so the diode and resistor codes matter
      repeat (24) begin
         d = {($urandom % 2) ? 4'ha : 4'($urandom), 4'($urandom)};
         wr(8'h0a, d);
         @(negedge clk);
         `CHK(chg.on, d[7:4] == 4'ha && ^d[3:2] && |d[1:0])
         `CHK(chg.res, d[1:0])
         `CHK(chg.diode, d[3:2] == 2'b10)
         rd(8'h0a, mdl[10]);
      end
      load(16'h1234, 8'h00);
      tk(3);
      rd(8'h08, 8'h34);
      rd(8'h09, 8'h12);
      load(16'h0100, 8'h02);
      tk(1);
      rd(8'h08, 8'h99);
      rd(8'h09, 8'h01);
      load(16'h0003, 8'h02);
      tk(5);
      `CHK(oe, 1'b0)
      mdl[11] = mdl[11] | 8'h40;
      rd(8'h0b, mdl[11]);
      rd(8'h08, 8'h00);
      wr(8'h0b, 8'hff);
      rd(8'h0b, mdl[11]);
      wr(8'h0b, 8'h00);
      rd(8'h0b, mdl[11]);
      load(16'h0000, 8'h02);
      tk(3);
      rd(8'h0b, mdl[11]);
      osc = 1'b0;
      repeat (2) @(negedge clk);
      osc = 1'b1;
      mdl[11] = mdl[11] | 8'h80;
      rd(8'h0b, mdl[11]);
      load(16'h0002, 8'h03);
      tk(2);
      wait_oe;
      `CHK(blk, 1'b1)
      `CHK(pout, 1'b0)
      hi_cycles(n);
      `CHK(n, HOLD)
      mdl[11] = mdl[11] | 8'h40;
      rd(8'h0b, mdl[11]);
      wr(8'h0c, 8'h00);
      btn = 1'b1;
      wait_oe;
      hi_cycles(n);
      `CHK(n, DEB)
      `CHK(blk, 1'b1)
      acc(1'b1, 8'h0c, 8'h03, 1'b0, d);
      btn = 1'b0;
      wait_oe;
      hi_cycles(n);
      `CHK(n, HOLD)
      rd(8'h0c, mdl[12]);
      for (int e = 0; e < 2; e++) begin
         wr(8'h0c, e ? 8'h80 : 8'h00);
         sup = 1'b0;
         wait_oe;
         `CHK(blk, 1'b1)
         repeat (5) @(negedge clk);
         sup = 1'b1;
         @(negedge clk);
         hi_cycles(n);
         `CHK(n, HOLD + e * OSC)
      end
      rd(8'h0c, mdl[12]);
      report_and_stop;
   end
endmodule : testbench

`default_nettype wire
